// ===== inc/teil_pkg.sv
package teil_pkg;
  // Command codes
  localparam logic [7:0] CMD_LOCAL = 8'h00;
  localparam logic [7:0] CMD_REM_HI = 8'h01;
  localparam logic [7:0] CMD_STATUS = 8'h02;
  localparam logic [7:0] CMD_CONFIG = 8'h03;
  localparam logic [7:0] CMD_MASK = 8'h04;
  localparam logic [7:0] CMD_LOC_HIGH = 8'h05;
  localparam logic [7:0] CMD_LOC_LOW = 8'h06;
  localparam logic [7:0] CMD_REM_HIGH_HI = 8'h07;
  localparam logic [7:0] CMD_REM_LOW_HI = 8'h08;
  localparam logic [7:0] CMD_LOCK = 8'h09;
  localparam logic [7:0] CMD_REM_LO = 8'h10;
  localparam logic [7:0] CMD_REM_HIGH_LO = 8'h13;
  localparam logic [7:0] CMD_REM_LOW_LO = 8'h14;
  localparam logic [7:0] CMD_REM_CRIT = 8'h19;
  localparam logic [7:0] CMD_LOC_CRIT = 8'h20;
  localparam logic [7:0] CMD_MFG = 8'hFE;
  localparam logic [7:0] CMD_DEV = 8'hFF;
  // Values after reset
  localparam logic [7:0] RST_CONFIG = 8'h80;
  localparam logic [7:0] RST_MASK = 8'h07;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [7:0] RST_LOC_HIGH = 8'h3C;
  localparam logic [7:0] RST_LOC_LOW = 8'h00;
  localparam logic [7:0] RST_REM_HIGH_HI = 8'h50;
  localparam logic [7:0] RST_REM_LOW_HI = 8'h00;
  localparam logic [7:0] RST_REM_LIM_LO = 8'h00;
  localparam logic [7:0] RST_REM_CRIT = 8'h64;
  localparam logic [7:0] RST_LOC_CRIT = 8'h46;
  localparam logic [4:0] RST_LOCK = 5'h00;
  // Configuration fields
  localparam int CFG_IE = 7;
  localparam int CFG_POWER_DOWN_BIT = 6;
  localparam int CFG_FQ_LSB = 4;
  localparam int CFG_RES_LSB = 2;
  localparam int CFG_RST = 0;
  // Protection bits
  localparam int LK_LCRIT = 0;
  localparam int LK_RCRIT = 1;
  localparam int LK_DIODE = 2;
  localparam int LK_POWER_DOWN_BIT = 3;
  localparam int LK_WARM = 4;
  // Status and mask bits
  localparam int ST_LCRIT = 0;
  localparam int ST_RCRIT = 1;
  localparam int ST_DIODE = 2;
  localparam int ST_RLOW = 3;
  localparam int ST_RHIGH = 4;
  localparam int ST_LLOW = 5;
  localparam int ST_LHIGH = 6;
  localparam int ST_DRDY = 7;
  localparam logic [7:0] MASK_SELF_CLEAR = 8'hFC;
  // Fault queue depths per code
  localparam logic [2:0] FQ_DEPTH_0 = 3'h1;
  localparam logic [2:0] FQ_DEPTH_1 = 3'h2;
  localparam logic [2:0] FQ_DEPTH_2 = 3'h4;
  localparam logic [2:0] FQ_DEPTH_3 = 3'h6;
  localparam int FQ_RHIGH = 0;
  localparam int FQ_RLOW = 1;
  localparam int FQ_LHIGH = 2;
  localparam int FQ_LLOW = 3;
  localparam int FQ_NUM = 4;
  typedef enum logic [1:0] {ACC_READ, ACC_WRITE, ACC_WORD, ACC_ARA} teil_access_t;
endpackage

// ===== rtl/teil_thermal_event_irq_lock.sv
`timescale 1ns/10ps
module teil_thermal_event_irq_lock
  import teil_pkg::*;
#(
  parameter logic [6:0] ARA_ADDR = 7'h48,
  parameter logic [7:0] MFG_CODE = 8'h5C, // Arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h10  // Arbitrary value
)(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic convDone,
  input wire logic [7:0] adcLocal,
  input wire logic [11:0] adcRemote,
  input wire logic remoteDiodeFault,
  input wire logic linkClk,
  input wire logic linkReq,
  input wire logic [1:0] linkKind,
  input wire logic [7:0] linkCmd,
  input wire logic [7:0] linkWrData,
  output logic linkBusy,
  output logic linkDone,
  output logic linkAck,
  output logic [15:0] linkRdData,
  output logic alertOut,
  output logic alertOe,
  output logic powerDown,
  output logic adcAbort,
  output logic [1:0] resolution
);
  // Link domain request capture
  logic reqTgl_r, linkBusy_r, linkDone_r, linkAck_r;
  logic [7:0] lCmd_r, lWdat_r;
  teil_access_t lKind_r;
  logic [15:0] linkRdData_r;
  logic ackS1_r, ackS2_r, ackS3_r, ackEdge;
  // System domain
  logic reqS1_r, reqS2_r, reqS3_r, reqEdge, ackTgl_r;
  logic dfS1_r, dfS2_r;
  logic ieR, shdnR;
  logic [1:0] fqR, resR;
  logic [7:0] statusR, maskR;
  logic [4:0] lockR;
  logic [7:0] locRes_r, remHi_r, remLo_r;
  logic [7:0] locHigh_r, locLow_r, remHighHi_r, remHighLo_r, remLowHi_r, remLowLo_r;
  logic [7:0] remCrit_r, locCrit_r;
  logic [15:0] rdData_r, rdNxt;
  logic replyOk_r, replyNxt;
  logic alertOe_r, alertOut_r, adcAbort_r;
  logic rdReq, wrReq, wordReq, araReq;
  logic cfgWr, lockWr, warm, shdnSet, shdnEnter, statRead, araOk;
  logic ieEff, convValid;
  logic [2:0] fqDepth;
  logic [7:0] ev, setv, maskClr, maskWrVal;
  logic [FQ_NUM-1:0] qCond, qHit, qPurge;
  logic signed [11:0] remNow, remHighLim, remLowLim;

  always_ff @(posedge linkClk or posedge rst)
  begin
    if (rst)
    begin
      reqTgl_r <= 1'b0;
      linkBusy_r <= 1'b0;
      lCmd_r <= 8'h00;
      lWdat_r <= 8'h00;
      lKind_r <= ACC_READ;
    end
    else if (linkReq && !linkBusy_r)
    begin
      reqTgl_r <= ~reqTgl_r;
      linkBusy_r <= 1'b1;
      lCmd_r <= linkCmd;
      lWdat_r <= linkWrData;
      lKind_r <= teil_access_t'(linkKind);
    end
    else if (ackEdge)
    begin
      linkBusy_r <= 1'b0;
    end
  end

  // Acknowledge toggle back into the link domain
  always_ff @(posedge linkClk or posedge rst)
  begin
    if (rst)
    begin
      ackS1_r <= 1'b0;
      ackS2_r <= 1'b0;
      ackS3_r <= 1'b0;
    end
    else
    begin
      ackS1_r <= ackTgl_r;
      ackS2_r <= ackS1_r;
      ackS3_r <= ackS2_r;
    end
  end
  assign ackEdge = ackS2_r ^ ackS3_r;

  // Answer words are held stable in the system domain until the next request
  always_ff @(posedge linkClk or posedge rst)
  begin
    if (rst)
    begin
      linkDone_r <= 1'b0;
      linkAck_r <= 1'b0;
      linkRdData_r <= 16'h0000;
    end
    else
    begin
      linkDone_r <= ackEdge;
      if (ackEdge)
      begin
        linkAck_r <= replyOk_r;
        linkRdData_r <= rdData_r;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      reqS1_r <= 1'b0;
      reqS2_r <= 1'b0;
      reqS3_r <= 1'b0;
      dfS1_r <= 1'b0;
      dfS2_r <= 1'b0;
    end
    else
    begin
      reqS1_r <= reqTgl_r;
      reqS2_r <= reqS1_r;
      reqS3_r <= reqS2_r;
      dfS1_r <= remoteDiodeFault;
      dfS2_r <= dfS1_r;
    end
  end
  assign reqEdge = reqS2_r ^ reqS3_r;

  // Request decode; link fields are stable while the toggle crosses
  assign rdReq = reqEdge && (lKind_r == ACC_READ);
  assign wrReq = reqEdge && (lKind_r == ACC_WRITE);
  assign wordReq = reqEdge && (lKind_r == ACC_WORD);
  assign araReq = reqEdge && (lKind_r == ACC_ARA);
  assign cfgWr = wrReq && (lCmd_r == CMD_CONFIG);
  assign lockWr = wrReq && (lCmd_r == CMD_LOCK);
  assign warm = cfgWr && lWdat_r[CFG_RST] && !lockR[LK_WARM];
  assign shdnSet = cfgWr && lWdat_r[CFG_POWER_DOWN_BIT] && !lockR[LK_POWER_DOWN_BIT] && !warm;
  assign shdnEnter = shdnSet && !shdnR;
  assign statRead = rdReq && (lCmd_r == CMD_STATUS);
  assign araOk = araReq && alertOe_r;
  assign ieEff = ieR | lockR[LK_LCRIT] | lockR[LK_RCRIT]
               | (lockR[LK_DIODE] & maskR[ST_DIODE]);
  assign convValid = convDone && !shdnR;

  always_comb
  begin
    case (fqR)
      2'b00: fqDepth = FQ_DEPTH_0;
      2'b01: fqDepth = FQ_DEPTH_1;
      2'b10: fqDepth = FQ_DEPTH_2;
      default: fqDepth = FQ_DEPTH_3;
    endcase
  end

  // Comparisons use the result being loaded in this conversion
  assign remNow = $signed(adcRemote);
  assign remHighLim = $signed({remHighHi_r, remHighLo_r[7:4]});
  assign remLowLim = $signed({remLowHi_r, remLowLo_r[7:4]});
  assign qCond[FQ_RHIGH] = remNow > remHighLim;
  assign qCond[FQ_RLOW] = remNow < remLowLim;
  assign qCond[FQ_LHIGH] = $signed(adcLocal) > $signed(locHigh_r);
  assign qCond[FQ_LLOW] = $signed(adcLocal) < $signed(locLow_r);
  assign qPurge[FQ_RHIGH] = wrReq && ((lCmd_r == CMD_REM_HIGH_HI) || (lCmd_r == CMD_REM_HIGH_LO));
  assign qPurge[FQ_RLOW] = wrReq && ((lCmd_r == CMD_REM_LOW_HI) || (lCmd_r == CMD_REM_LOW_LO));
  assign qPurge[FQ_LHIGH] = wrReq && (lCmd_r == CMD_LOC_HIGH);
  assign qPurge[FQ_LLOW] = wrReq && (lCmd_r == CMD_LOC_LOW);

  genvar gi;
  generate
    for (gi = 0; gi < FQ_NUM; gi++)
    begin : gQueue
      logic [2:0] qCnt_r;
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
          qCnt_r <= 3'h0;
        else if (qPurge[gi] || cfgWr || shdnEnter)
          qCnt_r <= 3'h0;
        else if (convValid)
          qCnt_r <= !qCond[gi] ? 3'h0 : (qCnt_r == FQ_DEPTH_3) ? qCnt_r : qCnt_r + 3'h1;
      end
      assign qHit[gi] = convValid && qCond[gi] && ((qCnt_r + 3'h1) >= fqDepth);
    end
  endgenerate

  // Each event is its own term, no cross dependencies
  always_comb
  begin
    ev = 8'h00;
    ev[ST_DRDY] = convValid;
    ev[ST_LHIGH] = qHit[FQ_LHIGH];
    ev[ST_RHIGH] = qHit[FQ_RHIGH];
    ev[ST_LLOW] = qHit[FQ_LLOW];
    ev[ST_RLOW] = qHit[FQ_RLOW];
    ev[ST_DIODE] = dfS2_r && !shdnR;
    ev[ST_RCRIT] = convValid && (remNow > $signed({remCrit_r, 4'h0}));
    ev[ST_LCRIT] = convValid && ($signed(adcLocal) > $signed(locCrit_r));
  end
  assign setv = ev & maskR;
  assign maskClr = setv & MASK_SELF_CLEAR
                 & ~{5'h00, lockR[LK_DIODE], 2'b00};

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      statusR <= RST_STATUS;
    else if (warm || shdnEnter)
      statusR <= RST_STATUS;
    else
      statusR <= (statRead ? RST_STATUS : statusR) | setv;
  end

  always_comb
  begin
    maskWrVal = lWdat_r;
    if (lockR[LK_LCRIT])
      maskWrVal[ST_LCRIT] = 1'b1;
    if (lockR[LK_RCRIT])
      maskWrVal[ST_RCRIT] = 1'b1;
    if (lockR[LK_DIODE])
      maskWrVal[ST_DIODE] = maskR[ST_DIODE];
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      maskR <= RST_MASK;
    else if (warm)
      maskR <= RST_MASK;
    else if (wrReq && (lCmd_r == CMD_MASK))
      maskR <= maskWrVal & ~maskClr;
    else if (lockWr)
      maskR <= (maskR | {6'h00, lWdat_r[LK_RCRIT], lWdat_r[LK_LCRIT]}) & ~maskClr;
    else
      maskR <= maskR & ~maskClr;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ieR <= RST_CONFIG[CFG_IE];
      shdnR <= RST_CONFIG[CFG_POWER_DOWN_BIT];
      fqR <= RST_CONFIG[CFG_FQ_LSB +: 2];
      resR <= RST_CONFIG[CFG_RES_LSB +: 2];
    end
    else if (warm)
    begin
      ieR <= RST_CONFIG[CFG_IE];
      shdnR <= RST_CONFIG[CFG_POWER_DOWN_BIT];
      fqR <= RST_CONFIG[CFG_FQ_LSB +: 2];
      resR <= RST_CONFIG[CFG_RES_LSB +: 2];
    end
    else if (cfgWr)
    begin
      ieR <= lWdat_r[CFG_IE];
      shdnR <= shdnSet;
      fqR <= lWdat_r[CFG_FQ_LSB +: 2];
      resR <= lWdat_r[CFG_RES_LSB +: 2];
    end
    else if (lockWr && (lWdat_r[LK_POWER_DOWN_BIT] || lWdat_r[LK_WARM]))
      shdnR <= 1'b0;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      lockR <= RST_LOCK;
    else if (warm)
      lockR <= RST_LOCK;
    else if (lockWr)
      lockR <= lockR | lWdat_r[4:0];
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      locHigh_r <= RST_LOC_HIGH;
      locLow_r <= RST_LOC_LOW;
      remHighHi_r <= RST_REM_HIGH_HI;
      remHighLo_r <= RST_REM_LIM_LO;
      remLowHi_r <= RST_REM_LOW_HI;
      remLowLo_r <= RST_REM_LIM_LO;
      remCrit_r <= RST_REM_CRIT;
      locCrit_r <= RST_LOC_CRIT;
    end
    else if (warm)
    begin
      locHigh_r <= RST_LOC_HIGH;
      locLow_r <= RST_LOC_LOW;
      remHighHi_r <= RST_REM_HIGH_HI;
      remHighLo_r <= RST_REM_LIM_LO;
      remLowHi_r <= RST_REM_LOW_HI;
      remLowLo_r <= RST_REM_LIM_LO;
      remCrit_r <= RST_REM_CRIT;
      locCrit_r <= RST_LOC_CRIT;
    end
    else if (wrReq)
    begin
      case (lCmd_r)
        CMD_LOC_HIGH: locHigh_r <= lWdat_r;
        CMD_LOC_LOW: locLow_r <= lWdat_r;
        CMD_REM_HIGH_HI: remHighHi_r <= lWdat_r;
        CMD_REM_HIGH_LO: remHighLo_r <= lWdat_r;
        CMD_REM_LOW_HI: remLowHi_r <= lWdat_r;
        CMD_REM_LOW_LO: remLowLo_r <= lWdat_r;
        CMD_REM_CRIT: if (!lockR[LK_RCRIT]) remCrit_r <= lWdat_r;
        CMD_LOC_CRIT: if (!lockR[LK_LCRIT]) locCrit_r <= lWdat_r;
        default: ;
      endcase
    end
  end

  // Results persist through power down
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      locRes_r <= RST_RESULT;
      remHi_r <= RST_RESULT;
      remLo_r <= RST_RESULT;
    end
    else if (warm)
    begin
      locRes_r <= RST_RESULT;
      remHi_r <= RST_RESULT;
      remLo_r <= RST_RESULT;
    end
    else if (convValid)
    begin
      locRes_r <= adcLocal;
      remHi_r <= adcRemote[11:4];
      remLo_r <= {adcRemote[3:0], 4'h0};
    end
  end

  always_comb
  begin
    rdNxt = rdData_r;
    replyNxt = replyOk_r;
    if (reqEdge)
    begin
      rdNxt = 16'h0000;
      replyNxt = 1'b0;
      if (rdReq)
      begin
        replyNxt = 1'b1;
        case (lCmd_r)
          CMD_LOCAL: rdNxt[7:0] = locRes_r;
          CMD_REM_HI: rdNxt[7:0] = remHi_r;
          CMD_STATUS: rdNxt[7:0] = statusR;
          CMD_CONFIG: rdNxt[7:0] = {ieEff, shdnR, fqR, resR, 2'b00};
          CMD_MASK: rdNxt[7:0] = maskR;
          CMD_LOC_HIGH: rdNxt[7:0] = locHigh_r;
          CMD_LOC_LOW: rdNxt[7:0] = locLow_r;
          CMD_REM_HIGH_HI: rdNxt[7:0] = remHighHi_r;
          CMD_REM_LOW_HI: rdNxt[7:0] = remLowHi_r;
          CMD_LOCK: rdNxt[7:0] = {3'b000, lockR};
          CMD_REM_LO: rdNxt[7:0] = remLo_r;
          CMD_REM_HIGH_LO: rdNxt[7:0] = remHighLo_r;
          CMD_REM_LOW_LO: rdNxt[7:0] = remLowLo_r;
          CMD_REM_CRIT: rdNxt[7:0] = remCrit_r;
          CMD_LOC_CRIT: rdNxt[7:0] = locCrit_r;
          CMD_MFG: rdNxt[7:0] = MFG_CODE;
          CMD_DEV: rdNxt[7:0] = DEV_CODE;
          default: replyNxt = 1'b0;
        endcase
      end
      else if (wordReq && (lCmd_r == CMD_REM_HI))
      begin
        replyNxt = 1'b1;
        rdNxt = {remHi_r, remLo_r};
      end
      else if (araOk)
      begin
        replyNxt = 1'b1;
        rdNxt[7:0] = {ARA_ADDR, 1'b0};
      end
      else if (wrReq)
        replyNxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rdData_r <= 16'h0000;
      replyOk_r <= 1'b0;
      ackTgl_r <= 1'b0;
      adcAbort_r <= 1'b0;
      alertOut_r <= 1'b0;
    end
    else
    begin
      rdData_r <= rdNxt;
      replyOk_r <= replyNxt;
      adcAbort_r <= cfgWr;
      alertOut_r <= 1'b0;
      if (reqEdge)
        ackTgl_r <= ~ackTgl_r;
    end
  end

  // New events win over a release in the same cycle
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      alertOe_r <= 1'b0;
    else if (warm || shdnEnter)
      alertOe_r <= 1'b0;
    else if ((setv != 8'h00) && ieEff)
      alertOe_r <= 1'b1;
    else if (statRead || araOk || !ieEff)
      alertOe_r <= 1'b0;
  end

  assign linkBusy = linkBusy_r;
  assign linkDone = linkDone_r;
  assign linkAck = linkAck_r;
  assign linkRdData = linkRdData_r;
  assign alertOut = alertOut_r;
  assign alertOe = alertOe_r;
  assign powerDown = shdnR;
  assign adcAbort = adcAbort_r;
  assign resolution = resR;

  a_alert_needs_ie: assert property (@(posedge sys_clk) disable iff (rst)
    !ieEff |=> !alertOe_r) else $error("alert driven with enable off");
  a_status_read_clr: assert property (@(posedge sys_clk) disable iff (rst)
    (statRead && setv == 8'h00) |=> (statusR == 8'h00) && !alertOe_r)
    else $error("status read did not clear");
  a_flag_needs_mask: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 ((statusR & ~$past(statusR) & ~$past(maskR)) == 8'h00))
    else $error("flag set with mask off");
  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    (!statRead && !warm && !shdnEnter) |=> ((statusR & $past(statusR)) == $past(statusR)))
    else $error("flag lost without clear");
  a_ready_event: assert property (@(posedge sys_clk) disable iff (rst)
    (convValid && maskR[ST_DRDY] && !warm && !shdnEnter) |=> statusR[ST_DRDY] && !maskR[ST_DRDY])
    else $error("data ready not raised");
  a_powerdown_clr: assert property (@(posedge sys_clk) disable iff (rst)
    shdnEnter |=> (statusR == 8'h00) && !alertOe_r && powerDown)
    else $error("power down entry incomplete");
  a_guard_holds_pd: assert property (@(posedge sys_clk) disable iff (rst)
    lockR[LK_POWER_DOWN_BIT] |-> !shdnR) else $error("power down with guard set");
  a_word_coherent: assert property (@(posedge sys_clk) disable iff (rst)
    (wordReq && lCmd_r == CMD_REM_HI) |=> rdData_r == {$past(remHi_r), $past(remLo_r)} && replyOk_r)
    else $error("word read mismatch");
  a_warm_defaults: assert property (@(posedge sys_clk) disable iff (rst)
    warm |=> (maskR == RST_MASK) && (lockR == RST_LOCK) && !shdnR && (locCrit_r == RST_LOC_CRIT))
    else $error("warm restart incomplete");
  a_guard_set_once: assert property (@(posedge sys_clk) disable iff (rst)
    !warm |=> ((lockR & $past(lockR)) == $past(lockR))) else $error("guard bit cleared");
  a_crit_mask_fix: assert property (@(posedge sys_clk) disable iff (rst)
    lockR[LK_LCRIT] |-> maskR[ST_LCRIT]) else $error("critical mask not fixed");
endmodule // teil_thermal_event_irq_lock

// ===== testbench/teil_host_model.sv
`timescale 1ns/10ps
module teil_host_model
  import teil_pkg::*;
(
  input wire logic linkClk,
  output logic linkReq,
  output logic [1:0] linkKind,
  output logic [7:0] linkCmd,
  output logic [7:0] linkWrData,
  input wire logic linkBusy,
  input wire logic linkDone,
  input wire logic linkAck,
  input wire logic [15:0] linkRdData,
  output logic timedOut
);
  int busyMiss = 0;
  initial
  begin
    linkReq = 1'h0;
    linkKind = 2'h0;
    linkCmd = 8'h00;
    linkWrData = 8'h00;
    timedOut = 1'h0;
  end
  // One request at a time, strobed for one cycle, fields held until the answer edge
  task automatic xfer(input teil_access_t k, input logic [7:0] c, input logic [7:0] w,
                      output logic [15:0] rdat, output logic ack);
    int n;
    n = 0;
    @(posedge linkClk);
    linkReq <= 1'h1;
    linkKind <= k;
    linkCmd <= c;
    linkWrData <= w;
    @(posedge linkClk);
    linkReq <= 1'h0;
    while (linkDone !== 1'h1 && n < 40)
    begin
      @(posedge linkClk);
      // Busy must stand from the edge after the request was taken
      if (n == 0 && linkBusy !== 1'h1)
        busyMiss++;
      n++;
    end
    // Busy drops in the cycle that carries the answer
    if (linkBusy !== 1'h0)
      busyMiss++;
    if (n >= 40)
      timedOut <= 1'h1;
    rdat = linkRdData;
    ack = linkAck;
    // Released qualifiers stop showing the old value
    linkCmd <= ~c;
    linkWrData <= ~w;
  endtask
endmodule // teil_host_model

// ===== testbench/teil_thermal_event_irq_lock_bench.sv
`timescale 1ns/10ps
module teil_thermal_event_irq_lock_bench
  import teil_pkg::*;
;
  logic sys_clk = 0, rst = 1, linkClk = 0, convDone = 0, remoteDiodeFault = 0;
  logic [7:0] adcLocal = 0;
  logic [11:0] adcRemote = 0;
  logic linkReq, linkBusy, linkDone, linkAck, alertOut, alertOe, powerDown, adcAbort, tmo;
  logic [1:0] linkKind, resolution;
  logic [7:0] linkCmd, linkWrData, mSt, mMask;
  logic [15:0] linkRdData, d;
  logic a, mAlert;
  int num_errors = 0, check_count = 0, seed = 32'h7349a22b;
  int nAbort = 0, nCfg = 0;
  int dep[4] = '{1, 2, 4, 6};
  always #50 sys_clk = ~sys_clk;
  initial #7 forever #16 linkClk = ~linkClk;
  teil_thermal_event_irq_lock uut (.sys_clk, .rst, .convDone, .adcLocal, .adcRemote,
    .remoteDiodeFault, .linkClk, .linkReq, .linkKind, .linkCmd, .linkWrData, .linkBusy,
    .linkDone, .linkAck, .linkRdData, .alertOut, .alertOe, .powerDown, .adcAbort, .resolution);
  teil_host_model host (.linkClk, .linkReq, .linkKind, .linkCmd, .linkWrData, .linkBusy,
    .linkDone, .linkAck, .linkRdData, .timedOut(tmo));
  // Abort pulses, one per configuration write
  always @(posedge sys_clk)
    if (adcAbort === 1'h1)
      nAbort++;
  task automatic chk(string nm, logic [16:0] seen, logic [16:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(logic [7:0] c, logic [15:0] exp, string nm);
    host.xfer(ACC_READ, c, 8'h00, d, a);
    chk(nm, d, exp);
  endtask
  task automatic wr(logic [7:0] c, logic [7:0] v);
    host.xfer(ACC_WRITE, c, v, d, a);
    if (c == CMD_CONFIG)
      nCfg++;
  endtask
  task automatic pulse(logic [7:0] l, logic [11:0] r);
    @(posedge sys_clk);
    convDone <= 1'h1;
    adcLocal <= l;
    adcRemote <= r;
    @(posedge sys_clk);
    convDone <= 1'h0;
    repeat (3) @(posedge sys_clk);
  endtask
  // Model with default limits and queue depth one
  task automatic conv(logic [7:0] l, logic [11:0] r);
    logic [7:0] f;
    f = 8'h80;
    f[0] = $signed(l) > $signed(8'h46);
    f[1] = $signed(r) > $signed(12'h640);
    f[3] = $signed(r) < 0;
    f[4] = $signed(r) > $signed(12'h500);
    f[5] = $signed(l) < 0;
    f[6] = $signed(l) > $signed(8'h3C);
    f = f & mMask;
    mSt = mSt | f;
    mMask = mMask & ~(f & 8'hFC);
    mAlert = mAlert | (f != 8'h00);
    pulse(l, r);
  endtask
  task automatic print_verdict();
    if (tmo)
      num_errors++;
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #500us;
    num_errors++;
    print_verdict();
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'h0;
    rd(CMD_CONFIG, 16'h0080, "config rst");
    rd(CMD_MASK, 16'h0007, "mask rst");
    rd(CMD_LOCK, 16'h0000, "lock rst");
    rd(CMD_REM_CRIT, 16'h0064, "rcrit rst");
    wr(CMD_CONFIG, 8'h8C);
    chk("resolution", resolution, 16'h0003);
    wr(CMD_MASK, 8'hFF);
    {mSt, mMask, mAlert} = {8'h00, 8'hFF, 1'h0};
    conv(8'h50, 12'h000);
    conv(8'h50, 12'h000);
    chk("alert", alertOe, mAlert);
    host.xfer(ACC_ARA, 8'h00, 8'h00, d, a);
    chk("ara", {a, d}, 17'h10090);
    chk("alert ara", alertOe, 16'h0000);
    host.xfer(ACC_ARA, 8'h00, 8'h00, d, a);
    chk("ara idle", a, 16'h0000);
    rd(CMD_STATUS, {8'h00, mSt}, "sticky");
    rd(CMD_MASK, {8'h00, mMask}, "mask");
    mSt = 8'h00;
    conv(8'h10, 12'hABC);
    host.xfer(ACC_WORD, CMD_REM_HI, 8'h00, d, a);
    chk("word", {a, d}, 17'h1ABC0);
    host.xfer(ACC_WORD, CMD_LOCAL, 8'h00, d, a);
    chk("word bad", a, 16'h0000);
    rd(CMD_STATUS, {8'h00, mSt}, "status");
    for (int i = 0; i < 12; i++)
    begin
      wr(CMD_MASK, 8'hFF);
      {mSt, mMask, mAlert} = {8'h00, 8'hFF, 1'h0};
      conv(8'($random(seed)), 12'($random(seed)));
      chk("alert", alertOe, mAlert);
      chk("pin", alertOut, 16'h0000);
      rd(CMD_STATUS, {8'h00, mSt}, "status");
      rd(CMD_MASK, {8'h00, mMask}, "mask");
      rd(CMD_STATUS, 16'h0000, "cleared");
      chk("released", alertOe, 16'h0000);
    end
    wr(CMD_CONFIG, 8'h0C);
    wr(CMD_MASK, 8'hFF);
    {mSt, mMask} = {8'h00, 8'hFF};
    conv(8'h7F, 12'h7FF);
    chk("no ie", alertOe, 16'h0000);
    rd(CMD_STATUS, {8'h00, mSt}, "status");
    for (int c = 0; c < 4; c++)
    begin
      wr(CMD_CONFIG, {2'h2, 2'(c), 4'hC});
      wr(CMD_MASK, 8'h40);
      repeat (dep[c] - 1) pulse(8'h40, 12'h100);
      rd(CMD_STATUS, 16'h0000, "queue");
      pulse(8'h40, 12'h100);
      rd(CMD_STATUS, 16'h0040, "queue");
    end
    wr(CMD_MASK, 8'hFF);
    pulse(8'h50, 12'h000);
    wr(CMD_CONFIG, 8'hCC);
    chk("pd", {powerDown, alertOe}, 16'h0002);
    rd(CMD_STATUS, 16'h0000, "pd status");
    rd(CMD_LOCAL, 16'h0050, "pd result");
    wr(CMD_LOCK, 8'h08);
    chk("pd guard", powerDown, 16'h0000);
    wr(CMD_CONFIG, 8'hCC);
    rd(CMD_CONFIG, 16'h008C, "pd held");
    wr(CMD_LOCK, 8'h00);
    rd(CMD_LOCK, 16'h0008, "set once");
    wr(CMD_LOC_CRIT, 8'h30);
    wr(CMD_CONFIG, 8'h81);
    rd(CMD_LOCK, 16'h0000, "warm lock");
    rd(CMD_LOC_CRIT, 16'h0046, "warm lim");
    rd(CMD_MASK, 16'h0007, "warm mask");
    @(posedge sys_clk);
    remoteDiodeFault <= 1'h1;
    repeat (6) @(posedge sys_clk);
    chk("diode", alertOe, 16'h0001);
    remoteDiodeFault <= 1'h0;
    rd(CMD_STATUS, 16'h0004, "diode st");
    rd(CMD_MASK, 16'h0003, "diode mask");
    wr(CMD_LOCK, 8'h01);
    wr(CMD_CONFIG, 8'h00);
    rd(CMD_CONFIG, 16'h0080, "ie forced");
    wr(CMD_LOC_CRIT, 8'h10);
    rd(CMD_LOC_CRIT, 16'h0046, "crit frozen");
    wr(CMD_MASK, 8'h00);
    rd(CMD_MASK, 16'h0001, "mask fixed");
    pulse(8'h7F, 12'h000);
    chk("crit alert", alertOe, 16'h0001);
    rd(CMD_STATUS, 16'h0001, "crit st");
    wr(CMD_CONFIG, 8'hC0);
    wr(CMD_LOCK, 8'h11);
    chk("warm guard", powerDown, 16'h0000);
    wr(CMD_CONFIG, 8'h81);
    rd(CMD_LOCK, 16'h0011, "no warm");
    wr(CMD_MASK, 8'h04);
    wr(CMD_LOCK, 8'h04);
    wr(CMD_MASK, 8'h00);
    rd(CMD_MASK, 16'h0005, "diode frozen");
    @(posedge sys_clk);
    remoteDiodeFault <= 1'h1;
    repeat (6) @(posedge sys_clk);
    remoteDiodeFault <= 1'h0;
    repeat (3) @(posedge sys_clk);
    chk("guard alert", alertOe, 16'h0001);
    rd(CMD_STATUS, 16'h0004, "guard st");
    rd(CMD_MASK, 16'h0005, "mask kept");
    chk("abort", 17'(nAbort), 17'(nCfg));
    chk("busy", 17'(host.busyMiss), 17'h00000);
    print_verdict();
  end
endmodule // teil_thermal_event_irq_lock_bench
